// ### core/dam_top.sv
// Function
// - Codes leave as unsigned straight binary
// - Standby with clock stopped halts conversions
// - Disable high floats all output lines
// - Select low gives Q, high gives I
// - Pipeline advances on both clock edges
// - Strap chooses 1 V, 2 V, external or programmable reference
// - Supply strap selects external reference
// - Code appears three periods after sampling
// - Each channel latch updates on rising edges seen in run state with the run bit set
// - Both channels sample at same instant
module dam_top (
   input wire logic sys_clk_in, // 50 MHz clock
   input wire logic sys_rst_in, // Sync reset, high
   input wire logic conv_clk_in, // Converter clock level
   input wire logic [7:0] i_sample_in, // I input, binary
   input wire logic [7:0] q_sample_in, // Q input, binary
   input wire logic channel_select_in, // High I, low Q
   input wire logic output_disable_in, // High floats bus
   input wire logic standby_input_in, // Low power request
   input wire logic [1:0] reference_mode_strap_in, // Strap level
   output logic [7:0] output_code_lines_out, // Shared bus
   output logic [7:0] output_code_oe_out, // Drive enables
   output logic [1:0] ref_mode_out, // Active reference mode
   output logic standby_out, // Static state
   output logic sample_valid_out, // Buffered pair ready
   input wire logic sample_ready_in, // Sink ready
   output logic [15:0] sample_pair_out, // {I, Q}
   input wire logic [7:0] s_axi_awaddr, // AXI write addr
   input wire logic s_axi_awvalid, // AXI
   output logic s_axi_awready, // AXI
   input wire logic [31:0] s_axi_wdata, // AXI
   input wire logic [3:0] s_axi_wstrb, // AXI
   input wire logic s_axi_wvalid, // AXI
   output logic s_axi_wready, // AXI
   output logic [1:0] s_axi_bresp, // AXI
   output logic s_axi_bvalid, // AXI
   input wire logic s_axi_bready, // AXI
   input wire logic [7:0] s_axi_araddr, // AXI
   input wire logic s_axi_arvalid, // AXI
   output logic s_axi_arready, // AXI
   output logic [31:0] s_axi_rdata, // AXI
   output logic [1:0] s_axi_rresp, // AXI
   output logic s_axi_rvalid, // AXI
   input wire logic s_axi_rready // AXI
);
   localparam int W = dam_pkg::CODE_W;
   localparam int STAGES = 2 * dam_pkg::LATENCY_PERIODS;

   logic [31:0] ctrl;
   logic clk_q;
   logic rise;
   logic fall;
   logic active;
   logic [W-1:0] i_pipe [STAGES];
   logic [W-1:0] q_pipe [STAGES];
   logic [W-1:0] i_latch;
   logic [W-1:0] q_latch;
   logic sel;
   logic dis;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [31:0] next_rdata;
   logic buf_ready;
   logic strap_caught;
   dam_pkg::dam_ref_t ref_mode;
   dam_pkg::dam_pwr_t pwr;

   // ----------------------------------------
   // Converter clock edges and power state
   // ----------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         clk_q <= 1'b0;
      end else begin
         clk_q <= conv_clk_in;
      end
   end

   assign rise = conv_clk_in && !clk_q;
   assign fall = !conv_clk_in && clk_q;
   assign active = (pwr == dam_pkg::DAM_RUN) && ctrl[dam_pkg::CTRL_RUN_BIT];

   // Standby only sticks once the clock has really stopped
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         pwr <= dam_pkg::DAM_RUN;
      end else begin
         case (pwr)
            dam_pkg::DAM_RUN: begin
               if ((standby_input_in || ctrl[dam_pkg::CTRL_STANDBY_INPUT_BIT])
                   && !rise && !fall) begin
                  pwr <= dam_pkg::DAM_STANDBY;
               end
            end
            dam_pkg::DAM_STANDBY: begin
               if (!standby_input_in && !ctrl[dam_pkg::CTRL_STANDBY_INPUT_BIT]) begin
                  pwr <= dam_pkg::DAM_RUN;
               end else if (rise || fall) begin
                  pwr <= dam_pkg::DAM_RUN; // Clock restarted: resume
               end
            end
            default: pwr <= dam_pkg::DAM_RUN;
         endcase
      end
   end

   // ----------------------------------------
   // Pipeline: six half-period stages
   // ----------------------------------------
   // Stage 0 samples both channels together on a rising edge; each
   // later stage moves on either edge, giving three full periods.
   genvar g;
   generate
      for (g = 0; g < STAGES; g++) begin : g_stage
         always_ff @(posedge sys_clk_in) begin
            if (sys_rst_in) begin
               i_pipe[g] <= '0;
               q_pipe[g] <= '0;
            end else if (g == 0) begin
               if (active && rise) begin
                  i_pipe[g] <= i_sample_in;
                  q_pipe[g] <= q_sample_in;
               end
            end else if (active && (rise || fall)) begin
               i_pipe[g] <= i_pipe[(g == 0) ? 0 : g - 1];
               q_pipe[g] <= q_pipe[(g == 0) ? 0 : g - 1];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         i_latch <= '0;
         q_latch <= '0;
      end else if (active && rise) begin
         i_latch <= i_pipe[STAGES-2];
         q_latch <= q_pipe[STAGES-2];
      end
   end

   // ----------------------------------------
   // Output mux and three-state control
   // ----------------------------------------
   assign sel = channel_select_in || ctrl[dam_pkg::CTRL_SEL_BIT];
   assign dis = output_disable_in || ctrl[dam_pkg::CTRL_DIS_BIT];

   // Select is sampled every cycle into a registered bus, so a host tying it to the clock
   // sees the matching channel one system cycle after each phase begins.
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         output_code_lines_out <= '0;
         output_code_oe_out <= '0;
      end else begin
         output_code_lines_out <= sel ? i_latch : q_latch;
         output_code_oe_out <= dis ? 8'h00 : 8'hFF;
      end
   end

   // ----------------------------------------
   // Reference strap, caught after reset release
   // ----------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         strap_caught <= 1'b0;
         ref_mode <= dam_pkg::DAM_REF_2V;
      end else if (!strap_caught) begin
         strap_caught <= 1'b1;
         ref_mode <= dam_pkg::dam_ref_t'(reference_mode_strap_in);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         ref_mode_out <= 2'h0;
         standby_out <= 1'b0;
      end else begin
         ref_mode_out <= ref_mode;
         standby_out <= pwr == dam_pkg::DAM_STANDBY;
      end
   end

   // ----------------------------------------
   // Sample stream buffer
   // ----------------------------------------
   // Overrun is counted in status rather than stalling the converter.
   logic [15:0] overruns;
   logic push_ok;
   assign push_ok = active && rise;

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         overruns <= '0;
      end else if (push_ok && !buf_ready && overruns != 16'hFFFF) begin
         overruns <= overruns + 16'h0001;
      end
   end

   dam_skid u_buf (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .in_valid_in(push_ok),
      .in_ready_out(buf_ready),
      .in_data_in({i_pipe[STAGES-2], q_pipe[STAGES-2]}),
      .out_valid_out(sample_valid_out),
      .out_ready_in(sample_ready_in),
      .out_data_out(sample_pair_out)
   );

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= dam_pkg::RESP_OKAY;
         ctrl <= dam_pkg::CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_held && w_held && !s_axi_bvalid) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == dam_pkg::CTRL_ADDR) begin
               s_axi_bresp <= dam_pkg::RESP_OKAY;
               for (int b = 0; b < 4; b++) begin
                  if (w_strb[b]) begin
                     ctrl[8*b +: 8] <= w_data[8*b +: 8];
                  end
               end
            end else begin
               s_axi_bresp <= dam_pkg::RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (s_axi_araddr)
         dam_pkg::CTRL_ADDR: next_rdata = ctrl;
         dam_pkg::STAT_ADDR: next_rdata = {overruns, 9'h000,
            ~buf_ready, sample_valid_out, 1'b0, output_code_oe_out[0],
            standby_out, ref_mode};
         dam_pkg::IDATA_ADDR: next_rdata = {24'h000000, i_latch};
         dam_pkg::QDATA_ADDR: next_rdata = {24'h000000, q_latch};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= dam_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= (s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] ==
            2'h0) ? dam_pkg::RESP_OKAY : dam_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   assign s_axi_arready = !s_axi_rvalid;
endmodule

// ### core/dam_pkg.sv
package dam_pkg;
   // ----------------------------------------
   // Widths and timing
   // ----------------------------------------
   localparam int CODE_W = 8;
   localparam int LATENCY_PERIODS = 3;
   localparam int BUF_DEPTH = 2;
   localparam int CLK_PERIOD_NS = 20;
   localparam int MUX_DELAY_NS = 5;
   localparam int MUX_DELAY_CYC =
      (MUX_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------
   // AXI4-Lite register map
   // ----------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STAT_ADDR = 8'h04;
   localparam logic [7:0] IDATA_ADDR = 8'h08;
   localparam logic [7:0] QDATA_ADDR = 8'h0C;
   localparam int CTRL_SEL_BIT = 0;
   localparam int CTRL_DIS_BIT = 1;
   localparam int CTRL_STANDBY_INPUT_BIT = 2;
   localparam int CTRL_RUN_BIT = 3;
   localparam int CTRL_REF_LSB = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // Reference modes and power states
   // ----------------------------------------
   typedef enum logic [1:0] {
      DAM_REF_1V = 2'b00,
      DAM_REF_2V = 2'b01,
      DAM_REF_EXT = 2'b10,
      DAM_REF_PROG = 2'b11
   } dam_ref_t;
   typedef enum logic [1:0] {
      DAM_RUN = 2'b00,
      DAM_STANDBY = 2'b01,
      DAM_IDLE = 2'b10
   } dam_pwr_t;
endpackage

// ### core/dam_skid.sv
module dam_skid (
   input wire logic sys_clk_in, // Clock
   input wire logic sys_rst_in, // Sync reset
   input wire logic in_valid_in, // Source valid
   output logic in_ready_out, // Space available
   input wire logic [15:0] in_data_in, // I and Q pair
   output logic out_valid_out, // Word ready
   input wire logic out_ready_in, // Sink ready
   output logic [15:0] out_data_out // Head word
);
   logic [15:0] mem [dam_pkg::BUF_DEPTH];
   logic rd_ptr;
   logic wr_ptr;
   logic [1:0] count;
   logic push;
   logic pop;

   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign in_ready_out = count != 2'(dam_pkg::BUF_DEPTH);
   assign out_valid_out = count != 2'h0;
   assign out_data_out = mem[rd_ptr];

   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + 2'(push) - 2'(pop);
      end
   end
endmodule

// ### tb/dam_chk.sv
module dam_chk (
   input wire logic sys_clk_in, // Clock
   input wire logic sys_rst_in, // Reset
   input wire logic conv_clk_in, // Converter clock
   input wire logic channel_select_in, // Channel pick
   input wire logic output_disable_in, // Float request
   input wire logic [7:0] output_code_lines_out, // Bus
   input wire logic [7:0] output_code_oe_out, // Enables
   input wire logic standby_out, // Static state
   input wire logic sample_valid_out, // Pair offered
   input wire logic sample_ready_in, // Sink ready
   input wire logic [15:0] sample_pair_out, // Head pair
   input wire logic s_axi_arvalid, // AXI
   input wire logic s_axi_arready, // AXI
   input wire logic s_axi_rvalid, // AXI
   input wire logic s_axi_bvalid, // AXI
   input wire logic s_axi_bready // AXI
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (sys_rst_in);
   // ----------------------------------------
   // Output side
   // ----------------------------------------
   sequence s_quiet;
      standby_out && output_code_oe_out == 8'hFF && $stable(channel_select_in);
   endsequence
   a_float_bus: assert property (
      output_disable_in |=> output_code_oe_out == 8'h00)
      else $error("Bus driven while disabled");
   a_oe_whole: assert property (
      output_code_oe_out == 8'h00 || output_code_oe_out == 8'hFF)
      else $error("Bus enables split");
   a_standby_frozen: assert property (
      s_quiet ##1 s_quiet |=> $stable(output_code_lines_out))
      else $error("Bus moved in standby");
   a_wake_on_edge: assert property (
      $changed(conv_clk_in) |-> ##2 !standby_out)
      else $error("Standby held with clock running");
   a_pair_cause: assert property (
      $rose(sample_valid_out) |-> $past(conv_clk_in))
      else $error("Pair pushed without clock edge");
   a_pair_hold: assert property (
      sample_valid_out && !sample_ready_in |=>
         sample_valid_out && $stable(sample_pair_out))
      else $error("Stalled pair lost");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read answer late");
   a_write_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("Write response dropped");
endmodule

bind dam_top dam_chk i_chk (.*);

// ### tb/dam_sink.sv
module dam_sink (
   input wire logic sys_clk_in, // Clock
   input wire logic sys_rst_in, // Reset
   input wire logic stall_in, // Hold off taking pairs
   input wire logic sample_valid_in, // Pair offered
   input wire logic [15:0] sample_pair_in, // {I, Q}
   input wire logic sel_in, // Channel select level
   input wire logic [7:0] code_in, // Shared bus
   output logic sample_ready_out // Taking pairs
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Downstream de-multiplexer
   // ----------------------------------------
   logic [15:0] got[$];
   logic [7:0] lat_i;
   logic [7:0] lat_q;
   logic sel_d;
   assign sample_ready_out = !stall_in && !sys_rst_in;
   always_ff @(posedge sys_clk_in) begin
      if (!sys_rst_in && sample_valid_in && sample_ready_out)
         got.push_back(sample_pair_in);
   end
   // The bus lags select by one cycle, so latch on the delayed level
   always_ff @(posedge sys_clk_in) begin
      sel_d <= sel_in;
      if (sel_d)
         lat_i <= code_in;
      else
         lat_q <= code_in;
   end
endmodule

// ### tb/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_in = '0, sys_rst_in = 1'h1, conv_clk_in = '0, stall = '0;
   logic channel_select_in = '0, output_disable_in = '0;
   logic standby_input_in = '0, standby_out, sample_valid_out;
   logic [7:0] i_sample_in = '0, q_sample_in = '0, output_code_lines_out;
   logic [7:0] output_code_oe_out, s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [1:0] reference_mode_strap_in = '0, ref_mode_out;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [15:0] sample_pair_out;
   logic sample_ready_in, s_axi_awvalid = '0, s_axi_awready;
   logic s_axi_wvalid = '0, s_axi_wready, s_axi_bvalid, s_axi_bready = '0;
   logic s_axi_arvalid = '0, s_axi_arready, s_axi_rvalid, s_axi_rready = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_v;
   logic [3:0] s_axi_wstrb = '0;
   int n_fail = 0, comparisons = 0, cyc = 0, n0;
   dam_top i_dut (.*);
   dam_sink i_sink (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .stall_in(stall), .sample_valid_in(sample_valid_out),
      .sample_pair_in(sample_pair_out), .sel_in(channel_select_in),
      .code_in(output_code_lines_out), .sample_ready_out(sample_ready_in));
   initial forever #10 sys_clk_in = ~sys_clk_in;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("Comparisons %0d, failures %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Ceiling well above the few hundred cycles the tests need
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         stop_test();
      end
   end
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic clk(int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge sys_clk_in);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge sys_clk_in); // Idle edge before any next request
   endtask
   task automatic rd(logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge sys_clk_in);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      rd_v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge sys_clk_in); // Idle edge before any next request
   endtask
   // One converter period of four system cycles, sample at the rise
   task automatic conv(int k);
      i_sample_in <= 8'(8'h11 * k);
      q_sample_in <= 8'(8'hFF - 8'h11 * k);
      conv_clk_in <= 1'h1;
      clk(2);
      conv_clk_in <= 1'h0;
      clk(2);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_strap();
      for (int k = 0; k < 4; k++) begin
         reference_mode_strap_in <= 2'(k);
         sys_rst_in <= 1'h1;
         clk(12);
         sys_rst_in <= 1'h0;
         clk(4);
         chk("ref mode", 32'(k), 32'(ref_mode_out));
      end
      $display("strap test done");
   endtask
   task automatic t_regs();
      rd(dam_pkg::CTRL_ADDR);
      chk("ctrl reset", dam_pkg::CTRL_RESET, rd_v);
      rd(8'h10);
      chk("unmapped read", {30'h0, dam_pkg::RESP_SLVERR}, {rd_v[31:2], rs});
      wr(8'h10, 32'h0000_000F);
      chk("unmapped write", 32'(dam_pkg::RESP_SLVERR), 32'(rs));
      wr(dam_pkg::CTRL_ADDR, 32'h0000_000A);
      clk(2);
      chk("ctrl float", 32'h00, 32'(output_code_oe_out));
      wr(dam_pkg::CTRL_ADDR, dam_pkg::CTRL_RESET);
      $display("register test done");
   endtask
   task automatic t_pipe();
      logic [7:0] e;
      logic [15:0] p;
      channel_select_in <= 1'h1;
      n0 = i_sink.got.size();
      for (int k = 0; k < 8; k++) begin
         conv(k);
         if (k >= 3) begin
            e = 8'(8'h11 * (k - 3));
            chk("bus", 32'(e), 32'(output_code_lines_out));
         end
      end
      for (int k = 3; k < 8; k++) begin
         e = 8'(8'h11 * (k - 3));
         p = {e, 8'hFF - e};
         chk("pair", 32'(p), 32'(i_sink.got[n0 + k]));
      end
      channel_select_in <= 1'h0;
      clk(3);
      chk("latch I", 32'h44, 32'(i_sink.lat_i));
      chk("latch Q", 32'hBB, 32'(i_sink.lat_q));
      rd(dam_pkg::IDATA_ADDR);
      chk("I reg", 32'h0000_0044, rd_v);
      rd(dam_pkg::QDATA_ADDR);
      chk("Q reg", 32'h0000_00BB, rd_v);
      output_disable_in <= 1'h1;
      clk(2);
      chk("oe off", 32'h00, 32'(output_code_oe_out));
      output_disable_in <= 1'h0;
      clk(2);
      chk("oe on", 32'hFF, 32'(output_code_oe_out));
      $display("pipeline test done");
   endtask
   task automatic t_standby();
      standby_input_in <= 1'h1;
      clk(4);
      chk("standby in", 32'h1, 32'(standby_out));
      standby_input_in <= 1'h0;
      conv(1);
      chk("standby out", 32'h0, 32'(standby_out));
      $display("standby test done");
   endtask
   task automatic t_buffer();
      stall <= 1'h1;
      n0 = i_sink.got.size();
      for (int k = 0; k < 4; k++)
         conv(k);
      rd(dam_pkg::STAT_ADDR);
      chk("full, overruns", 32'h0002_0060, rd_v & 32'hFFFF_0060);
      stall <= 1'h0;
      clk(4);
      chk("drained", 32'(n0 + 2), 32'(i_sink.got.size()));
      chk("empty", 32'h0, 32'(sample_valid_out));
      $display("buffer test done");
   endtask
   initial begin
      t_strap();
      t_regs();
      t_pipe();
      t_standby();
      t_buffer();
      stop_test();
   end
endmodule
